//--- hcs_defines.svh
// Timing counts, encodings and reset values of the command sequencer
`ifndef HCS_DEFINES_SVH
`define HCS_DEFINES_SVH

// ----------------------------------------
// Clock and times
// ----------------------------------------
`define HCS_CLK_MHZ 200
`define HCS_LOCK_BASE_MS 260
`define HCS_LOCK_MAX_MS 32000
`define HCS_AUTH_LIFE_MS 1000
`define HCS_MS_TO_CYC(ms) (40'(ms) * 40'd1000 * 40'(`HCS_CLK_MHZ))
`define HCS_LOCK_BASE_CYC `HCS_MS_TO_CYC(`HCS_LOCK_BASE_MS)
`define HCS_LOCK_MAX_CYC `HCS_MS_TO_CYC(`HCS_LOCK_MAX_MS)
`define HCS_AUTH_LIFE_CYC `HCS_MS_TO_CYC(`HCS_AUTH_LIFE_MS)

// ----------------------------------------
// Verify mode field and misc
// ----------------------------------------
`define HCS_MODE_DIRECT 2'h0
`define HCS_MODE_SIGNED 2'h1
`define HCS_MODE_NOCHECK 2'h2
`define HCS_MODE_OFF 2'h3
`define HCS_MIX_ROUNDS 80
`define HCS_LFSR_SEED 160'h1
`define HCS_DATA_W 160

`endif

//--- hcs_device_end.sv
// Device end: command checks, lock states, session keys and answers
`timescale 1ns/100ps
`include "hcs_defines.svh"
// Functional notes
// RULE1: Keep only authentication session key, drop others
// RULE2: Digest check failure locks until reset
// RULE3: Digest check allowed once per reset
// RULE4: Mode 00 compares digest with stored hash
// RULE5: Mode 01 hashes digest, compares with signature
// RULE6: Mode 11 disables check, startup needs none
// RULE7: Host runs digest check before startup; code requires it only in modes 00 and 01, not in mode 10
// RULE8: Mode 10 answers OK without computing
// RULE9: Host sends digest then signature, 20 bytes
// RULE10: Startup clears state, returns 20 random bytes
// RULE11: Startup returns digest of nonce and key
// RULE12: Startup runs only once per reset
// RULE13: Host proof mismatch locks until reset
// RULE14: Host proof must directly follow startup
// RULE15: First tag step stores cryptogram and key
// RULE16: First tag step clears earlier session state
// RULE17: Second tag step mismatch causes security lockout
// RULE18: Tag authentication expires one second later
// RULE19: Lockout 260 ms, doubling, capped at 32 s
// RULE20: Host relays tag values between device, tag
// RULE21: Distinct status code for every outcome
module hcs_device_end
  import hcs_pkg::*;
#(
  parameter logic [39:0] LOCK_BASE_CYC = `HCS_LOCK_BASE_CYC,
  parameter logic [39:0] LOCK_MAX_CYC = `HCS_LOCK_MAX_CYC,
  parameter logic [39:0] AUTH_LIFE_CYC = `HCS_AUTH_LIFE_CYC,
  parameter int MIX_ROUNDS = `HCS_MIX_ROUNDS
) (
  input wire logic clock,
  input wire logic resetn,
  hcs_link_if.device link,
  input wire logic [1:0] verify_mode,
  input wire logic [159:0] stored_image_hash,
  input wire logic [159:0] chip_shared_key,
  input wire logic [159:0] host_shared_key,
  input wire logic [159:0] tag_master_key,
  output logic reset_lock_state,
  output logic auth_valid
);

  hcs_dstate_t state_q;
  hcs_op_t op_q;
  logic [159:0] a_q, b_q, q_q, nonce_q, lfsr_q;
  logic verify_used_q, startup_used_q, proof_ok_q;
  logic prev_startup_q, prev_auth1_q, prev_enc1_q;
  logic [63:0] c_q, s_q, ce_q;
  logic [39:0] delay_q, next_delay_q, life_q;
  hcs_outcome_t pre, post, outcome;
  logic take, fin, mix_start, mix_done, ok;
  logic [159:0] mix_a, mix_b, mix_out;
  logic [63:0] q64, ch, cx, sx;

  function automatic hcs_status_t to_status(hcs_outcome_t oc);
    case (oc)
      OC_OK: to_status = ST_OK;
      OC_LOCK: to_status = ST_RESET_LOCK;
      OC_DELAY: to_status = ST_DELAY;
      default: to_status = ST_FAIL;
    endcase
  endfunction

  // ----------------------------------------
  // Handshake and engine selection
  // ----------------------------------------
  assign link.req_ready = (state_q == DS_IDLE);
  assign link.busy = (state_q != DS_IDLE) || reset_lock_state; // see RULE2
  assign take = link.req_valid && (state_q == DS_IDLE);
  assign q64 = q_q[63:0];
  assign ch = mix_out[63:0];
  assign cx = mix_out[127:64];
  assign sx = mix_out[159:96];
  assign mix_a = (op_q == OP_PROOF) ? nonce_q :
                 (op_q == OP_AUTH1) ? {32'h0, a_q[63:0], q64} :
                 (op_q == OP_ENC1) ? {32'h0, c_q, q64} : a_q;
  assign mix_b = (op_q == OP_VERIFY) ? stored_image_hash :
                 (op_q == OP_STARTUP) ? chip_shared_key :
                 (op_q == OP_PROOF) ? host_shared_key :
                 (op_q == OP_AUTH1) ? (tag_master_key ^ b_q) :
                 {96'h0, s_q};
  assign mix_start = (state_q == DS_EXEC) && (pre == OC_MIX);
  assign fin = ((state_q == DS_EXEC) && (pre != OC_MIX))
            || ((state_q == DS_WAIT) && mix_done);
  assign outcome = (state_q == DS_WAIT) ? post : pre;
  assign ok = (outcome == OC_OK);

  hcs_mix #(.ROUNDS(MIX_ROUNDS)) u_mix (
    .clock(clock),
    .resetn(resetn),
    .start(mix_start),
    .in_a(mix_a),
    .in_b(mix_b),
    .done(mix_done),
    .result(mix_out)
  );

  // ----------------------------------------
  // Checks made before any computation
  // ----------------------------------------
  always_comb begin
    pre = OC_MIX;
    if (reset_lock_state) begin
      pre = OC_LOCK; // see RULE2
    end else if (prev_startup_q && op_q != OP_PROOF) begin
      pre = OC_LOCK; // see RULE14
    end else if (prev_auth1_q && op_q != OP_AUTH2) begin
      pre = OC_DELAY;
    end else if (prev_enc1_q && op_q != OP_ENC2) begin
      pre = OC_DELAY;
    end else begin
      case (op_q)
        OP_VERIFY: begin
          if (verify_used_q || startup_used_q) pre = OC_LOCK; // see RULE3
          else if (verify_mode == `HCS_MODE_OFF) pre = OC_FAIL; // see RULE6
          else if (verify_mode == `HCS_MODE_NOCHECK) pre = OC_OK; // see RULE8
          else if (verify_mode == `HCS_MODE_DIRECT)
            pre = (a_q == stored_image_hash) ? OC_OK : OC_LOCK; // see RULE4
        end
        OP_STARTUP: begin
          if (startup_used_q) pre = OC_DELAY; // see RULE12
          else if (!verify_mode[1] && !verify_used_q)
            pre = OC_LOCK; // see RULE7
        end
        OP_PROOF: begin
          if (!prev_startup_q) pre = OC_LOCK; // see RULE14
        end
        OP_AUTH1: begin
          if (!proof_ok_q) pre = OC_LOCK;
        end
        OP_AUTH2: begin
          if (!proof_ok_q) pre = OC_LOCK;
          else if (!prev_auth1_q) pre = OC_FAIL;
          else pre = (a_q[63:0] == c_q) ? OC_OK : OC_DELAY; // see RULE17
        end
        OP_ENC1: begin
          if (!proof_ok_q) pre = OC_LOCK;
          else if (!auth_valid) pre = OC_FAIL; // see RULE18
        end
        OP_ENC2: begin
          if (!proof_ok_q) pre = OC_LOCK;
          else if (!prev_enc1_q) pre = OC_FAIL;
          else pre = (a_q[63:0] == ce_q) ? OC_OK : OC_DELAY;
        end
        default: pre = OC_DELAY;
      endcase
    end
  end

  // Comparisons after the engine has run
  always_comb begin
    case (op_q)
      OP_VERIFY: post = (mix_out == b_q) ? OC_OK : OC_LOCK; // see RULE5
      OP_PROOF: post = (mix_out == a_q) ? OC_OK : OC_LOCK; // see RULE13
      default: post = OC_OK;
    endcase
  end

  // ----------------------------------------
  // Sequencer and answer
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= DS_IDLE;
      op_q <= OP_VERIFY;
      a_q <= 160'h0;
      b_q <= 160'h0;
      q_q <= 160'h0;
      link.rsp_valid <= 1'b0;
      link.rsp_status <= ST_OK;
      link.rsp_data_a <= 160'h0;
      link.rsp_data_b <= 160'h0;
    end else begin
      link.rsp_valid <= 1'b0;
      case (state_q)
        DS_IDLE: begin
          if (take) begin
            op_q <= link.req_op;
            a_q <= link.req_arg_a;
            b_q <= link.req_arg_b;
            q_q <= lfsr_q;
            state_q <= DS_EXEC;
          end
        end
        DS_EXEC: begin
          if (pre == OC_MIX) state_q <= DS_WAIT;
        end
        DS_WAIT: ;
        DS_RESP: state_q <= (delay_q != 40'h0) ? DS_DELAY : DS_IDLE;
        DS_DELAY: begin
          if (delay_q == 40'h1) state_q <= DS_IDLE;
        end
        default: state_q <= DS_IDLE;
      endcase
      if (fin) begin
        state_q <= DS_RESP;
        link.rsp_valid <= 1'b1;
        link.rsp_status <= to_status(outcome); // see RULE21
        link.rsp_data_a <= 160'h0;
        link.rsp_data_b <= 160'h0;
        if (ok && op_q == OP_STARTUP) begin
          link.rsp_data_a <= q_q; // see RULE10
          link.rsp_data_b <= mix_out; // see RULE11
        end
        if (ok && (op_q == OP_AUTH1 || op_q == OP_ENC1))
          link.rsp_data_a <= {32'h0, q64, ch};
      end
    end
  end

  // ----------------------------------------
  // Session state and penalties
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reset_lock_state <= 1'b0;
      verify_used_q <= 1'b0;
      startup_used_q <= 1'b0;
      proof_ok_q <= 1'b0;
      prev_startup_q <= 1'b0;
      prev_auth1_q <= 1'b0;
      prev_enc1_q <= 1'b0;
      nonce_q <= 160'h0;
      c_q <= 64'h0;
      s_q <= 64'h0;
      ce_q <= 64'h0;
      auth_valid <= 1'b0;
      life_q <= 40'h0;
      delay_q <= 40'h0;
      next_delay_q <= LOCK_BASE_CYC;
      lfsr_q <= `HCS_LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[158:0],
                 lfsr_q[159] ^ lfsr_q[158] ^ lfsr_q[141] ^ lfsr_q[140]};
      if (auth_valid) begin
        life_q <= life_q - 40'h1;
        if (life_q == 40'h1) auth_valid <= 1'b0; // see RULE18
      end
      if (state_q == DS_DELAY) delay_q <= delay_q - 40'h1;
      if (fin) begin
        prev_startup_q <= ok && (op_q == OP_STARTUP);
        prev_auth1_q <= ok && (op_q == OP_AUTH1);
        prev_enc1_q <= ok && (op_q == OP_ENC1);
        if (op_q == OP_VERIFY) verify_used_q <= 1'b1; // see RULE3
        if (outcome == OC_LOCK) reset_lock_state <= 1'b1; // see RULE2
        if (outcome == OC_DELAY) begin
          delay_q <= next_delay_q; // see RULE19
          next_delay_q <= (next_delay_q >= (LOCK_MAX_CYC >> 1)) ?
                          LOCK_MAX_CYC : (next_delay_q << 1);
        end
        if (ok && op_q == OP_STARTUP) begin
          startup_used_q <= 1'b1; // see RULE12
          nonce_q <= q_q;
          proof_ok_q <= 1'b0; // see RULE10
          auth_valid <= 1'b0;
          c_q <= 64'h0;
          s_q <= 64'h0;
          ce_q <= 64'h0;
        end
        if (ok && op_q == OP_PROOF) proof_ok_q <= 1'b1;
        if (ok && op_q == OP_AUTH1) begin
          auth_valid <= 1'b0; // see RULE16
          ce_q <= 64'h0; // see RULE16
          c_q <= cx; // see RULE15
          s_q <= sx; // see RULE15
        end
        if (ok && op_q == OP_AUTH2) begin
          auth_valid <= 1'b1;
          life_q <= AUTH_LIFE_CYC; // see RULE18
        end
        // Only the expected cryptogram is kept; the key output is dropped
        if (ok && op_q == OP_ENC1) ce_q <= cx; // see RULE1
      end
    end
  end

endmodule

//--- hcs_host_end.sv
// System processor end: orders commands and relays values to the device
`timescale 1ns/100ps
module hcs_host_end
  import hcs_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  hcs_link_if.host link,
  input wire logic [1:0] verify_mode,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire hcs_op_t cmd_op,
  input wire logic [159:0] cmd_arg_a,
  input wire logic [159:0] cmd_arg_b,
  output logic done,
  output hcs_status_t done_status,
  output logic [159:0] done_data_a,
  output logic [159:0] done_data_b
);

  hcs_hstate_t state_q;
  hcs_op_t last_op_q;
  logic verify_sent_q, startup_sent_q, any_sent_q;
  logic take, refuse;

  // ----------------------------------------
  // Local ordering checks
  // ----------------------------------------
  // Refusing here spares the device a lock that only a reset can undo, or the delay of a repeated startup
  assign cmd_ready = (state_q == HS_IDLE) && !link.busy;
  assign take = cmd_valid && cmd_ready;
  assign refuse =
      ((cmd_op == OP_VERIFY) && (verify_sent_q || startup_sent_q)) // see RULE3
    || ((cmd_op == OP_STARTUP) && startup_sent_q) // see RULE12
    || ((cmd_op == OP_STARTUP) && !verify_mode[1]
        && !verify_sent_q) // see RULE7
    || ((cmd_op == OP_PROOF)
        && !(any_sent_q && last_op_q == OP_STARTUP)); // see RULE14

  // Digest in arg_a, signature in arg_b; tag values pass through as given
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= HS_IDLE;
      last_op_q <= OP_VERIFY;
      verify_sent_q <= 1'b0;
      startup_sent_q <= 1'b0;
      any_sent_q <= 1'b0;
      link.req_valid <= 1'b0;
      link.req_op <= OP_VERIFY;
      link.req_arg_a <= 160'h0;
      link.req_arg_b <= 160'h0;
      done <= 1'b0;
      done_status <= ST_OK;
      done_data_a <= 160'h0;
      done_data_b <= 160'h0;
    end else begin
      done <= 1'b0;
      case (state_q)
        HS_IDLE: begin
          if (take && refuse) begin
            done <= 1'b1;
            done_status <= ST_REFUSED;
            done_data_a <= 160'h0;
            done_data_b <= 160'h0;
          end else if (take) begin
            link.req_valid <= 1'b1;
            link.req_op <= cmd_op;
            link.req_arg_a <= cmd_arg_a; // see RULE9
            link.req_arg_b <= cmd_arg_b; // see RULE20
            last_op_q <= cmd_op;
            any_sent_q <= 1'b1;
            if (cmd_op == OP_VERIFY) verify_sent_q <= 1'b1;
            if (cmd_op == OP_STARTUP) startup_sent_q <= 1'b1;
            state_q <= HS_SEND;
          end
        end
        HS_SEND: begin
          if (link.req_ready) begin
            link.req_valid <= 1'b0;
            state_q <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (link.rsp_valid) begin
            done <= 1'b1;
            done_status <= link.rsp_status;
            done_data_a <= link.rsp_data_a;
            done_data_b <= link.rsp_data_b;
            state_q <= HS_IDLE;
          end
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

endmodule

//--- hcs_link_asserts.sv
// Link-level assertions for the two ends of the command sequencer
`timescale 1ns/100ps
`include "hcs_defines.svh"
module hcs_link_asserts
  import hcs_pkg::*;
#(
  parameter int MIX_ROUNDS = `HCS_MIX_ROUNDS,
  parameter logic [39:0] LOCK_MAX_CYC = `HCS_LOCK_MAX_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire hcs_op_t req_op,
  input wire logic rsp_valid,
  input wire hcs_status_t rsp_status,
  input wire logic [159:0] rsp_data_a,
  input wire logic [159:0] rsp_data_b,
  input wire logic busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ------------
  // Helper state
  // ------------
  localparam int ANS_MAX = MIX_ROUNDS + 3;
  wire take = req_valid && req_ready;
  wire is_lock = rsp_valid && rsp_status == ST_RESET_LOCK;
  hcs_op_t last_q;
  hcs_op_t prev_q;
  logic lock_q;
  logic [39:0] stall_q;

  // Ops are tracked at the take, so answers pair with the right request
  always_ff @(posedge clock) begin
    if (!resetn) begin
      last_q <= OP_ILLEGAL;
      prev_q <= OP_ILLEGAL;
    end else if (take) begin
      last_q <= req_op;
      prev_q <= last_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      lock_q <= 1'b0;
    end else if (is_lock) begin
      lock_q <= 1'b1;
    end
  end

  // Counts stalled cycles since the last answer; a counter, not a repeat
  always_ff @(posedge clock) begin
    if (!resetn || rsp_valid || req_ready) begin
      stall_q <= '0;
    end else begin
      stall_q <= stall_q + 40'h00_0000_0001;
    end
  end

  // ------------
  // Assertions
  // ------------
  chk_take_busy: assert property (take |=> busy && !req_ready)
    else $error("link stayed ready after a take");
  chk_answer_time: assert property (
    take |-> ##[2:ANS_MAX] rsp_valid)
    else $error("no answer in time");
  chk_pulse_one: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer strobe too long");
  chk_lock_holds: assert property (
    lock_q |-> busy && (!rsp_valid || rsp_status == ST_RESET_LOCK))
    else $error("left the locked state");
  chk_proof_order: assert property (
    rsp_valid && prev_q == OP_STARTUP && last_q != OP_PROOF
    |-> rsp_status == ST_RESET_LOCK)
    else $error("no lock on a broken startup order");
  chk_proof_fail: assert property (
    rsp_valid && last_q == OP_PROOF
    |-> rsp_status inside {ST_OK, ST_RESET_LOCK})
    else $error("bad proof status");
  chk_auth2_result: assert property (
    rsp_valid && !lock_q && last_q == OP_AUTH2 && prev_q == OP_AUTH1
    |-> rsp_status inside {ST_OK, ST_DELAY})
    else $error("bad tag check status");
  chk_delay_min: assert property (
    rsp_valid && rsp_status == ST_DELAY |=> !req_ready [*8])
    else $error("security delay too short");
  chk_delay_cap: assert property (!lock_q |-> stall_q <= LOCK_MAX_CYC)
    else $error("security delay above cap");
  chk_enc_keys: assert property (
    rsp_valid && last_q == OP_ENC1
    |-> rsp_data_a[159:128] == '0 && rsp_data_b == '0)
    else $error("encryption key leaked");
endmodule

//--- hcs_link_if.sv
// Command link between the system processor end and the device end
`timescale 1ns/100ps
interface hcs_link_if;
  import hcs_pkg::*;
  logic req_valid;
  logic req_ready;
  hcs_op_t req_op;
  logic [159:0] req_arg_a;
  logic [159:0] req_arg_b;
  logic rsp_valid;
  hcs_status_t rsp_status;
  logic [159:0] rsp_data_a;
  logic [159:0] rsp_data_b;
  logic busy;

  modport host (
    output req_valid, req_op, req_arg_a, req_arg_b,
    input req_ready, rsp_valid, rsp_status, rsp_data_a, rsp_data_b, busy
  );
  modport device (
    input req_valid, req_op, req_arg_a, req_arg_b,
    output req_ready, rsp_valid, rsp_status, rsp_data_a, rsp_data_b, busy
  );
endinterface

//--- hcs_mix.sv
// Iterative keyed mixing engine standing in for the digest and tag cipher
`timescale 1ns/100ps
`include "hcs_defines.svh"
module hcs_mix
  import hcs_pkg::*;
#(
  parameter int ROUNDS = `HCS_MIX_ROUNDS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic start,
  input wire logic [159:0] in_a,
  input wire logic [159:0] in_b,
  output logic done,
  output logic [159:0] result
);

  logic [159:0] key_q;
  logic [7:0] cnt_q;
  logic run_q;
  logic [159:0] rnd_d;

  // ----------------------------------------
  // One round: rotate, key in, round count in
  // ----------------------------------------
  assign rnd_d = {result[154:0], result[159:155]} ^ key_q
               ^ {152'h0, cnt_q} ^ {1'b0, result[159:1]};

  always_ff @(posedge clock) begin
    if (!resetn) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
      done <= 1'b0;
      result <= 160'h0;
      key_q <= 160'h0;
    end else begin
      done <= 1'b0;
      if (start) begin
        run_q <= 1'b1;
        cnt_q <= 8'(ROUNDS - 1);
        result <= in_a;
        key_q <= in_b;
      end else if (run_q) begin
        result <= rnd_d;
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          run_q <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

//--- hcs_pkg.sv
// Types shared by both ends of the command sequencer
package hcs_pkg;

  typedef enum logic [2:0] {
    OP_VERIFY = 3'h0,
    OP_STARTUP = 3'h1,
    OP_PROOF = 3'h2,
    OP_AUTH1 = 3'h3,
    OP_AUTH2 = 3'h4,
    OP_ENC1 = 3'h5,
    OP_ENC2 = 3'h6,
    OP_ILLEGAL = 3'h7
  } hcs_op_t;

  typedef enum logic [2:0] {
    ST_OK = 3'h0,
    ST_FAIL = 3'h1,
    ST_RESET_LOCK = 3'h2,
    ST_DELAY = 3'h3,
    ST_REFUSED = 3'h4
  } hcs_status_t;

  typedef enum logic [2:0] {
    OC_OK, OC_FAIL, OC_LOCK, OC_DELAY, OC_MIX
  } hcs_outcome_t;

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_EXEC = 3'h1,
    DS_WAIT = 3'h3,
    DS_RESP = 3'h2,
    DS_DELAY = 3'h6
  } hcs_dstate_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_SEND = 2'h1,
    HS_WAIT = 2'h3
  } hcs_hstate_t;

endpackage

//--- host_auth_command_sequencer_tb.sv
// Self-checking bench for both ends of the command sequencer
`timescale 1ns/100ps
module host_auth_command_sequencer_tb;
  import hcs_pkg::*;
  // ------------
  // Design and reference
  // ------------
  localparam int ROUNDS = 4;
  localparam logic [39:0] BASE = 40'h00_0000_0008;
  localparam logic [39:0] CAP = 40'h00_0000_0040;
  localparam logic [39:0] LIFE = 40'h00_0000_0032;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] mode = 2'h0;
  logic cmd_valid = 1'b0;
  hcs_op_t op = OP_VERIFY;
  logic [159:0] arg_a = '0;
  logic [159:0] arg_b = '0;
  logic [159:0] hash, ck, hk, tk, da, db;
  logic cmd_ready, done, lock, auth;
  hcs_status_t dst;
  logic [39:0] dly = '0;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  hcs_link_if link ();

  hcs_device_end #(.LOCK_BASE_CYC(BASE), .LOCK_MAX_CYC(CAP),
    .AUTH_LIFE_CYC(LIFE), .MIX_ROUNDS(ROUNDS)) u_hcs_device_end (
    .clock(clock), .resetn(resetn), .link(link), .verify_mode(mode),
    .stored_image_hash(hash), .chip_shared_key(ck),
    .host_shared_key(hk), .tag_master_key(tk),
    .reset_lock_state(lock), .auth_valid(auth));
  hcs_host_end u_hcs_host_end (.clock(clock), .resetn(resetn),
    .link(link), .verify_mode(mode), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(op), .cmd_arg_a(arg_a),
    .cmd_arg_b(arg_b), .done(done), .done_status(dst),
    .done_data_a(da), .done_data_b(db));
  hcs_link_asserts #(.MIX_ROUNDS(ROUNDS), .LOCK_MAX_CYC(CAP))
    u_hcs_link_asserts (.clock(clock), .resetn(resetn),
    .req_valid(link.req_valid), .req_ready(link.req_ready),
    .req_op(link.req_op), .rsp_valid(link.rsp_valid),
    .rsp_status(link.rsp_status), .rsp_data_a(link.rsp_data_a),
    .rsp_data_b(link.rsp_data_b), .busy(link.busy));

  always #2.5 clock = ~clock;

  // Length of the stall after the latest answer
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (link.rsp_valid) begin
      dly <= '0;
    end else if (link.busy) begin
      dly <= dly + 40'h00_0000_0001;
    end
  end

  always @(posedge clock) begin
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // ------------
  // Tasks
  // ------------
  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input bit ok, input string what);
    n_compared++;
    if (!ok) begin
      miscompares++;
      $display("BAD at %0t: %s", $time, what);
    end
  endtask

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
  endtask

  task automatic run(input hcs_op_t o, input logic [159:0] a, b,
      input hcs_status_t exp);
    int n;
    // One edge apart, so strobes never change twice in a time step
    tick();
    wait_ready();
    op = o;
    arg_a = a;
    arg_b = b;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    check(done === 1'b1 && dst === exp, "wrong command status");
  endtask

  // Host's and tag's own copy of the keyed mixing digest
  function automatic logic [159:0] mix_ref(input logic [159:0] a, k);
    logic [159:0] r;
    r = a;
    for (int i = ROUNDS - 1; i >= 0; i--) begin
      r = {r[154:0], r[159:155]} ^ k ^ {152'h0, 8'(i)} ^ {1'b0, r[159:1]};
    end
    return r;
  endfunction

  function automatic logic [159:0] rnd();
    return {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
  endfunction

  // Mode only changes under reset, as a strap would
  task automatic restart(input logic [1:0] m);
    resetn = 1'b0;
    mode = m;
    repeat (3) tick();
    resetn = 1'b1;
  endtask

  task automatic start_up(output logic [159:0] sn);
    logic [159:0] n, r;
    n = rnd();
    run(OP_STARTUP, n, '0, ST_OK);
    sn = da;
    r = mix_ref(n, ck);
    check(db === r, "chip answer");
    check(sn !== '0, "empty nonce");
  endtask

  task automatic login(input logic [1:0] m);
    logic [159:0] sn, r;
    restart(m);
    if (m != 2'h3) begin
      run(OP_VERIFY, hash, rnd(), ST_OK);
    end
    start_up(sn);
    r = mix_ref(sn, hk);
    run(OP_PROOF, r, '0, ST_OK);
  endtask

  task automatic tag_auth(output logic [63:0] ca, sa);
    logic [159:0] kb, r;
    logic [63:0] c;
    c = {$urandom(), $urandom()};
    kb = rnd();
    run(OP_AUTH1, {96'h0, c}, kb, ST_OK);
    r = mix_ref({32'h0, c, da[127:64]}, tk ^ kb);
    check(da[63:0] === r[63:0], "tag challenge");
    ca = r[127:64];
    sa = r[159:96];
  endtask

  // ------------
  // Tests
  // ------------
  initial begin
    logic [159:0] sn, r;
    logic [63:0] ca, sa, c2, s2;
    void'($urandom(17));
    hash = rnd();
    ck = rnd();
    hk = rnd();
    tk = rnd();
    login(2'h0);
    run(OP_VERIFY, hash, rnd(), ST_REFUSED);
    tag_auth(ca, sa);
    run(OP_AUTH2, {96'h0, ca}, '0, ST_OK);
    check(auth === 1'b1, "auth not live");
    for (int i = 0; i < 2; i++) begin
      run(OP_ENC1, '0, '0, ST_OK);
      r = mix_ref({32'h0, ca, da[127:64]}, {96'h0, sa});
      check(da[63:0] === r[63:0], "enc challenge");
      run(OP_ENC2, {96'h0, r[127:64]}, '0, ST_OK);
    end
    tag_auth(c2, s2);
    check(auth === 1'b0, "auth kept");
    run(OP_AUTH2, {96'h0, ca}, '0, ST_DELAY);
    wait_ready();
    check(dly === BASE, "first delay");
    $display("test session finished");
    for (int i = 1; i < 5; i++) begin
      run(OP_ILLEGAL, '0, '0, ST_DELAY);
      wait_ready();
      check(dly === ((BASE << i) > CAP ? CAP : BASE << i), "delay");
    end
    $display("test doubling finished");
    tag_auth(ca, sa);
    run(OP_AUTH2, {96'h0, ca}, '0, ST_OK);
    repeat (45) tick();
    check(auth === 1'b1, "auth expired early");
    repeat (10) tick();
    check(auth === 1'b0, "auth never expired");
    run(OP_ENC1, '0, '0, ST_FAIL);
    run(OP_AUTH2, '0, '0, ST_FAIL);
    run(OP_ENC2, '0, '0, ST_FAIL);
    $display("test expiry finished");
    restart(2'h0);
    run(OP_VERIFY, ~hash, '0, ST_RESET_LOCK);
    check(lock === 1'b1 && cmd_ready === 1'b0, "not locked");
    restart(2'h1);
    sn = rnd();
    r = mix_ref(sn, hash);
    run(OP_VERIFY, sn, r, ST_OK);
    restart(2'h1);
    run(OP_VERIFY, sn, ~r, ST_RESET_LOCK);
    restart(2'h2);
    run(OP_VERIFY, rnd(), rnd(), ST_OK);
    restart(2'h3);
    run(OP_VERIFY, hash, '0, ST_FAIL);
    $display("test modes finished");
    restart(2'h3);
    start_up(sn);
    run(OP_AUTH1, '0, '0, ST_RESET_LOCK);
    restart(2'h0);
    run(OP_STARTUP, rnd(), '0, ST_REFUSED);
    run(OP_PROOF, rnd(), '0, ST_REFUSED);
    login(2'h3);
    run(OP_STARTUP, rnd(), '0, ST_REFUSED);
    restart(2'h3);
    start_up(sn);
    run(OP_PROOF, rnd(), '0, ST_RESET_LOCK);
    $display("test ordering finished");
    stop_test();
  end
endmodule
